/* verilog/ppr_regs.svh */
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH

// Register map, byte address on an 8-bit plain port
`define PPR_ADDR_W        8
`define PPR_DATA_W        32
`define PPR_IN_BASE       8'h00
`define PPR_IN_LAST       8'h21
`define PPR_OUT_REGION    2'b01
`define PPR_CTRL_ADDR     8'h80
`define PPR_IDX_MSB       5
`define PPR_RGN_MSB       7
`define PPR_RGN_LSB       6

// Control register fields
`define PPR_CTRL_LOCK_BIT 0
`define PPR_CTRL_ONCE_BIT 1
`define PPR_LOCK_RST      1'b0

// Selector field
`define PPR_SEL_LSB       0
`define PPR_SEL_MSB       3
`define PPR_SEL_RST       4'h0
`define PPR_SEL_NULL      4'h0

// Peripheral input counts per pin group and their first flat index
`define PPR_N_IN          34
`define PPR_G1_N          9
`define PPR_G2_N          8
`define PPR_G3_N          9
`define PPR_G4_N          8
`define PPR_G1_BASE       0
`define PPR_G2_BASE       9
`define PPR_G3_BASE       17
`define PPR_G4_BASE       26
`define PPR_PINS          16

// Reserved selector codes per group, one bit per code
`define PPR_G1_RSV        16'h4200
`define PPR_G2_RSV        16'h0000
`define PPR_G3_RSV        16'h0100
`define PPR_G4_RSV        16'hC400

`endif

/* verilog/ppr_pkg.sv */
package ppr_pkg;

	typedef logic [3:0] ppr_sel_t;

	typedef enum logic [1:0]
	{
		PPR_RGN_NONE = 2'b00,
		PPR_RGN_IN   = 2'b01,
		PPR_RGN_OUT  = 2'b10,
		PPR_RGN_CTRL = 2'b11
	} ppr_region_t;

endpackage

/* verilog/ppr_top.sv */
// Summary of operation
// RQ1: Input and output routing use separate selectors
// RQ2: Each peripheral input has a 4-bit pin selector
// RQ3: Each pin has a 4-bit output selector
// RQ4: Output code zero disconnects; reset to zero
// RQ5: Group one inputs; codes 9, 14 reserved
// RQ6: Group two inputs use all sixteen codes
// RQ7: Group three inputs; code 8 reserved
// RQ8: Group four inputs; codes 10, 14, 15 reserved
// RQ9: Software avoids codes absent on small packages
// RQ10: Software avoids CAN receive selector without CAN
// RQ11: Software avoids pin shared with USB ID
// RQ12: Lock set makes selector writes silently ignored
// RQ13: Lock-once option keeps lock until reset
// RQ14: Remap wins over digital, never over analog
// RQ15: Reserved or absent code feeds inactive level
// RQ16: Selector write steers routing next cycle
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "ppr_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// One pin group: input synchroniser, input muxes, output muxes

module ppr_group #(
	parameter int          N_IN  = 9,
	parameter logic [15:0] RSV   = 16'h0000,
	parameter logic [15:0] AVAIL = 16'hFFFF,
	parameter logic [15:0] IDLE  = 16'h0000
) (
	input  wire logic                 clk,          // System clock
	input  wire logic                 rst_n,        // Async reset, active low
	input  wire logic [15:0]          pin_in,       // Pin levels, asynchronous
	input  wire logic [15:0]          pin_analog,   // Pin in analog mode
	input  wire logic [15:0]          periph_out,   // Peripheral outputs, code 0 unused
	input  wire logic [N_IN*4-1:0]    in_sel,       // Input selectors, flat
	input  wire logic [63:0]          out_sel,      // Output selectors, flat
	output logic      [N_IN-1:0]      periph_in,    // Routed peripheral inputs
	output logic      [15:0]          pin_out,      // Pin output level
	output logic      [15:0]          pin_oe        // Pin owned by a remapped output
);

	logic [15:0]     sync1_ff;
	logic [15:0]     sync2_ff;
	logic [N_IN-1:0] nxt_periph_in;
	logic [15:0]     nxt_pin_out;
	logic [15:0]     nxt_pin_oe;

	if (N_IN < 1 || N_IN > 16)
	begin : g_bad_n_in
		$error("ppr_group: N_IN must lie in 1..16");
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_ff <= 16'h0000;
			sync2_ff <= 16'h0000;
		end
		else
		begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
		end
	end

	always_comb
	begin
		ppr_pkg::ppr_sel_t code;
		code = `PPR_SEL_NULL;
		nxt_periph_in = '0;
		for (int i = 0; i < N_IN; i++)
		begin
			// Reserved or absent codes feed the idle level, never a stray pin
			code = in_sel[i*4 +: 4]; // see RQ2
			if (!RSV[code] && AVAIL[code]) // see RQ5 see RQ6 see RQ7 see RQ8 see RQ9
				nxt_periph_in[i] = sync2_ff[code] & ~pin_analog[code]; // see RQ14
			else
				nxt_periph_in[i] = IDLE[i]; // see RQ15
		end
	end

	always_comb
	begin
		ppr_pkg::ppr_sel_t code;
		code = `PPR_SEL_NULL;
		nxt_pin_out = 16'h0000;
		nxt_pin_oe = 16'h0000;
		for (int p = 0; p < `PPR_PINS; p++)
		begin
			// An analog pin keeps its analog function; remap never drives it
			code = out_sel[p*4 +: 4]; // see RQ3
			if (code != `PPR_SEL_NULL && !pin_analog[p]) // see RQ4 see RQ14
			begin
				nxt_pin_oe[p] = 1'b1;
				nxt_pin_out[p] = periph_out[code];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			periph_in <= '0;
			pin_out <= 16'h0000;
			pin_oe <= 16'h0000;
		end
		else
		begin
			periph_in <= nxt_periph_in;
			pin_out <= nxt_pin_out;
			pin_oe <= nxt_pin_oe;
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: register port, selector storage, lock, four pin groups

module ppr_top #(
	parameter logic [15:0] G1_AVAIL = 16'hFFFF,
	parameter logic [15:0] G2_AVAIL = 16'hFFFF,
	parameter logic [15:0] G3_AVAIL = 16'hFFFF,
	parameter logic [15:0] G4_AVAIL = 16'hFFFF,
	parameter logic [15:0] G1_IDLE  = 16'h0000,
	parameter logic [15:0] G2_IDLE  = 16'h0000,
	parameter logic [15:0] G3_IDLE  = 16'h0000,
	parameter logic [15:0] G4_IDLE  = 16'h0000
) (
	input  wire logic        clk,           // System clock, 50 MHz
	input  wire logic        rst_n,         // Async reset, active low
	input  wire logic [7:0]  reg_addr,      // Register byte address
	input  wire logic [31:0] reg_wdata,     // Write data
	input  wire logic        reg_we,        // Write strobe
	input  wire logic        reg_re,        // Read strobe
	output logic      [31:0] reg_rdata,     // Read data, cycle after strobe
	input  wire logic        lock_once_opt, // One write session option
	output logic             lock_state,    // Remap lock bit
	input  wire logic [15:0] g1_pin_in,     // Group one pin levels
	input  wire logic [15:0] g2_pin_in,     // Group two pin levels
	input  wire logic [15:0] g3_pin_in,     // Group three pin levels
	input  wire logic [15:0] g4_pin_in,     // Group four pin levels
	input  wire logic [15:0] g1_pin_analog, // Group one analog mode
	input  wire logic [15:0] g2_pin_analog, // Group two analog mode
	input  wire logic [15:0] g3_pin_analog, // Group three analog mode
	input  wire logic [15:0] g4_pin_analog, // Group four analog mode
	input  wire logic [15:0] g1_periph_out, // Group one peripheral outputs
	input  wire logic [15:0] g2_periph_out, // Group two peripheral outputs
	input  wire logic [15:0] g3_periph_out, // Group three peripheral outputs
	input  wire logic [15:0] g4_periph_out, // Group four peripheral outputs
	output logic      [8:0]  g1_periph_in,  // Group one routed inputs
	output logic      [7:0]  g2_periph_in,  // Group two routed inputs
	output logic      [8:0]  g3_periph_in,  // Group three routed inputs
	output logic      [7:0]  g4_periph_in,  // Group four routed inputs
	output logic      [15:0] g1_pin_out,    // Group one pin output level
	output logic      [15:0] g2_pin_out,    // Group two pin output level
	output logic      [15:0] g3_pin_out,    // Group three pin output level
	output logic      [15:0] g4_pin_out,    // Group four pin output level
	output logic      [15:0] g1_pin_oe,     // Group one pin owned by remap
	output logic      [15:0] g2_pin_oe,     // Group two pin owned by remap
	output logic      [15:0] g3_pin_oe,     // Group three pin owned by remap
	output logic      [15:0] g4_pin_oe      // Group four pin owned by remap
);

	ppr_pkg::ppr_sel_t     in_sel_ff [`PPR_N_IN];
	ppr_pkg::ppr_sel_t     out_sel_ff [4*`PPR_PINS];
	logic                  lock_ff;
	logic [31:0]           reg_rdata_ff;
	ppr_pkg::ppr_region_t  region;
	logic [5:0]            idx;
	logic                  sel_wr_ok;
	logic [`PPR_N_IN*4-1:0] in_flat;
	logic [255:0]          out_flat;

	assign reg_rdata = reg_rdata_ff;
	assign lock_state = lock_ff;

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks: group slices must tile the input selector map

	if (`PPR_G1_N + `PPR_G2_N + `PPR_G3_N + `PPR_G4_N != `PPR_N_IN)
	begin : g_bad_in_count
		$error("ppr_top: group input counts do not add up to the input count");
	end

	if (`PPR_G2_BASE != `PPR_G1_BASE + `PPR_G1_N || `PPR_G3_BASE != `PPR_G2_BASE + `PPR_G2_N
		|| `PPR_G4_BASE != `PPR_G3_BASE + `PPR_G3_N)
	begin : g_bad_base
		$error("ppr_top: group base indices overlap or leave gaps");
	end

	if (`PPR_IN_LAST != `PPR_N_IN - 1)
	begin : g_bad_in_last
		$error("ppr_top: last input selector address does not match the input count");
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	always_comb
	begin
		region = ppr_pkg::PPR_RGN_NONE;
		idx = reg_addr[`PPR_IDX_MSB:0];
		if (reg_addr <= `PPR_IN_LAST)
			region = ppr_pkg::PPR_RGN_IN;
		else if (reg_addr[`PPR_RGN_MSB:`PPR_RGN_LSB] == `PPR_OUT_REGION)
			region = ppr_pkg::PPR_RGN_OUT;
		else if (reg_addr == `PPR_CTRL_ADDR)
			region = ppr_pkg::PPR_RGN_CTRL;
	end

	assign sel_wr_ok = reg_we && !lock_ff; // see RQ12

	////////////////////////////////////////////////////////////////////////////
	// Selector storage

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `PPR_N_IN; i++)
				in_sel_ff[i] <= `PPR_SEL_RST;
		end
		else if (sel_wr_ok && region == ppr_pkg::PPR_RGN_IN)
		begin
			in_sel_ff[idx] <= reg_wdata[`PPR_SEL_MSB:`PPR_SEL_LSB]; // see RQ2 see RQ16
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 4*`PPR_PINS; i++)
				out_sel_ff[i] <= `PPR_SEL_RST; // see RQ4
		end
		else if (sel_wr_ok && region == ppr_pkg::PPR_RGN_OUT)
		begin
			out_sel_ff[idx] <= reg_wdata[`PPR_SEL_MSB:`PPR_SEL_LSB]; // see RQ3 see RQ16
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Remap lock

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lock_ff <= `PPR_LOCK_RST;
		else if (reg_we && region == ppr_pkg::PPR_RGN_CTRL)
		begin
			// The option is a static fuse level, read here without a synchroniser
			if (!(lock_ff && lock_once_opt)) // see RQ13
				lock_ff <= reg_wdata[`PPR_CTRL_LOCK_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_ff <= 32'h0000_0000;
		else
		begin
			// Read data stand for one cycle only, then fall back to zero
			reg_rdata_ff <= 32'h0000_0000;
			if (reg_re)
			begin
				unique case (region)
					ppr_pkg::PPR_RGN_IN:
						reg_rdata_ff[`PPR_SEL_MSB:`PPR_SEL_LSB] <= in_sel_ff[idx];
					ppr_pkg::PPR_RGN_OUT:
						reg_rdata_ff[`PPR_SEL_MSB:`PPR_SEL_LSB] <= out_sel_ff[idx];
					ppr_pkg::PPR_RGN_CTRL:
					begin
						reg_rdata_ff[`PPR_CTRL_LOCK_BIT] <= lock_ff;
						reg_rdata_ff[`PPR_CTRL_ONCE_BIT] <= lock_once_opt;
					end
					ppr_pkg::PPR_RGN_NONE:
						reg_rdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flatten selectors; input and output sets are independent

	always_comb
	begin
		in_flat = '0;
		out_flat = '0;
		for (int i = 0; i < `PPR_N_IN; i++)
			in_flat[i*4 +: 4] = in_sel_ff[i]; // see RQ1
		for (int i = 0; i < 4*`PPR_PINS; i++)
			out_flat[i*4 +: 4] = out_sel_ff[i]; // see RQ1
	end

	ppr_group #(
		.N_IN  (`PPR_G1_N),
		.RSV   (`PPR_G1_RSV),
		.AVAIL (G1_AVAIL),
		.IDLE  (G1_IDLE)
	) u_g1 (
		.clk        (clk),
		.rst_n      (rst_n),
		.pin_in     (g1_pin_in),
		.pin_analog (g1_pin_analog),
		.periph_out (g1_periph_out),
		.in_sel     (in_flat[`PPR_G1_BASE*4 +: `PPR_G1_N*4]),
		.out_sel    (out_flat[0 +: 64]),
		.periph_in  (g1_periph_in),
		.pin_out    (g1_pin_out),
		.pin_oe     (g1_pin_oe)
	);

	ppr_group #(
		.N_IN  (`PPR_G2_N),
		.RSV   (`PPR_G2_RSV),
		.AVAIL (G2_AVAIL),
		.IDLE  (G2_IDLE)
	) u_g2 (
		.clk        (clk),
		.rst_n      (rst_n),
		.pin_in     (g2_pin_in),
		.pin_analog (g2_pin_analog),
		.periph_out (g2_periph_out),
		.in_sel     (in_flat[`PPR_G2_BASE*4 +: `PPR_G2_N*4]),
		.out_sel    (out_flat[64 +: 64]),
		.periph_in  (g2_periph_in),
		.pin_out    (g2_pin_out),
		.pin_oe     (g2_pin_oe)
	);

	ppr_group #(
		.N_IN  (`PPR_G3_N),
		.RSV   (`PPR_G3_RSV),
		.AVAIL (G3_AVAIL),
		.IDLE  (G3_IDLE)
	) u_g3 (
		.clk        (clk),
		.rst_n      (rst_n),
		.pin_in     (g3_pin_in),
		.pin_analog (g3_pin_analog),
		.periph_out (g3_periph_out),
		.in_sel     (in_flat[`PPR_G3_BASE*4 +: `PPR_G3_N*4]),
		.out_sel    (out_flat[128 +: 64]),
		.periph_in  (g3_periph_in),
		.pin_out    (g3_pin_out),
		.pin_oe     (g3_pin_oe)
	);

	ppr_group #(
		.N_IN  (`PPR_G4_N),
		.RSV   (`PPR_G4_RSV),
		.AVAIL (G4_AVAIL),
		.IDLE  (G4_IDLE)
	) u_g4 (
		.clk        (clk),
		.rst_n      (rst_n),
		.pin_in     (g4_pin_in),
		.pin_analog (g4_pin_analog),
		.periph_out (g4_periph_out),
		.in_sel     (in_flat[`PPR_G4_BASE*4 +: `PPR_G4_N*4]),
		.out_sel    (out_flat[192 +: 64]),
		.periph_in  (g4_periph_in),
		.pin_out    (g4_pin_out),
		.pin_oe     (g4_pin_oe)
	);

endmodule

/* bench/ppr_top_props.sv */
`timescale 1ns/1ps
module ppr_top_props (
	input wire logic        clk,           // Clock
	input wire logic        rst_n,         // Reset
	input wire logic [7:0]  reg_addr,      // Address
	input wire logic [31:0] reg_wdata,     // Write data
	input wire logic        reg_we,        // Write
	input wire logic        reg_re,        // Read
	input wire logic [31:0] reg_rdata,     // Read data
	input wire logic        lock_once_opt, // Option
	input wire logic        lock_state,    // Lock
	input wire logic [15:0] g2_pin_analog, // Analog
	input wire logic [15:0] g2_pin_out,    // Level
	input wire logic [15:0] g2_pin_oe      // Owned
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence ctrl_wr;
		reg_we && reg_addr == 8'h80;
	endsequence

	chk_rdata_idle: assert property (!reg_re |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	chk_sel_upper: assert property (reg_re && reg_addr < 8'h80 |=> reg_rdata[31:4] == 28'h0)
		else $error("selector upper bits not zero");
	chk_ctrl_read: assert property (reg_re && reg_addr == 8'h80
		|=> reg_rdata[1:0] == {$past(lock_once_opt), $past(lock_state)})
		else $error("control read wrong");
	chk_lock_set: assert property (ctrl_wr ##0 reg_wdata[0] |=> lock_state)
		else $error("lock not set");
	chk_once_keep: assert property (lock_state && lock_once_opt |=> lock_state)
		else $error("lock cleared in one-session mode");
	chk_lock_clear: assert property (ctrl_wr ##0 !reg_wdata[0] && !(lock_state && lock_once_opt)
		|=> !lock_state)
		else $error("lock not cleared");
	chk_lock_stable: assert property (!(reg_we && reg_addr == 8'h80) |=> $stable(lock_state))
		else $error("lock moved without write");
	chk_analog_oe: assert property (1'b1 |=> (g2_pin_oe & $past(g2_pin_analog)) == 16'h0)
		else $error("analog pin driven by remap");
	chk_out_owned: assert property ((g2_pin_out & ~g2_pin_oe) == 16'h0)
		else $error("pin driven while not owned");
endmodule

bind ppr_top ppr_top_props chk_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
	.reg_rdata, .lock_once_opt, .lock_state, .g2_pin_analog, .g2_pin_out, .g2_pin_oe);

/* bench/ppr_far_model.sv */
`timescale 1ns/1ps
module ppr_far_model (
	input  wire logic [15:0] lvl,        // Pattern from the bench
	output logic      [15:0] pin_lvl,    // Pin levels
	output logic      [15:0] periph_lvl  // Peripheral outputs by code
);
	// Pins and peripherals hold plain levels; one pattern feeds every group
	// Full-featured part: every pin present, CAN fitted, pin identification unused
	assign pin_lvl = lvl;
	assign periph_lvl = lvl;
endmodule

/* bench/test_peripheral_pin_remap.sv */
`timescale 1ns/1ps
module test_peripheral_pin_remap;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_we = 1'b0;
	logic        reg_re = 1'b0;
	logic        lock_once_opt = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [15:0] lvl = 16'h0000;
	logic [15:0] ana = 16'h0000;
	logic [31:0] reg_rdata;
	logic        lock_state;
	logic [15:0] pin_lvl, per_lvl;
	logic [15:0] g1_pin_out, g2_pin_out, g3_pin_out, g4_pin_out;
	logic [15:0] g1_pin_oe, g2_pin_oe, g3_pin_oe, g4_pin_oe;
	logic [8:0]  g1_periph_in, g3_periph_in;
	logic [7:0]  g2_periph_in, g4_periph_in;
	logic [33:0] all_in;
	int          error_cnt = 0;
	int          checked = 0;

	// Flat input order equals the input selector address
	assign all_in = {g4_periph_in, g3_periph_in, g2_periph_in, g1_periph_in};

	ppr_far_model far_u (.lvl(lvl), .pin_lvl(pin_lvl), .periph_lvl(per_lvl));

	ppr_top dut_u (
		.clk, .rst_n, .reg_addr, .reg_wdata, .reg_we,
		.reg_re, .reg_rdata, .lock_once_opt, .lock_state,
		.g1_pin_in(pin_lvl), .g2_pin_in(pin_lvl), .g3_pin_in(pin_lvl), .g4_pin_in(pin_lvl),
		.g1_pin_analog(ana), .g2_pin_analog(ana), .g3_pin_analog(ana), .g4_pin_analog(ana),
		.g1_periph_out(per_lvl), .g2_periph_out(per_lvl), .g3_periph_out(per_lvl),
		.g4_periph_out(per_lvl), .g1_periph_in, .g2_periph_in, .g3_periph_in, .g4_periph_in,
		.g1_pin_out, .g2_pin_out, .g3_pin_out, .g4_pin_out,
		.g1_pin_oe, .g2_pin_oe, .g3_pin_oe, .g4_pin_oe
	);

	initial
	begin
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		chk("read data", exp, reg_rdata);
	endtask

	// Two synchroniser stages plus the output flop
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////////////

	task automatic s_in(input logic [7:0] a, input logic [15:0] rsv);
		for (int c = 0; c < 16; c++)
		begin
			wr(a, c);
			lvl <= 16'h0001 << c;
			settle();
			chk("selected pin", {31'h0, !rsv[c]}, {31'h0, all_in[a]});
			@(posedge clk);
			lvl <= ~(16'h0001 << c);
			settle();
			chk("other pins", 32'h0, {31'h0, all_in[a]});
		end
		wr(a, 32'h2);
		ana <= 16'h0004;
		lvl <= 16'hFFFF;
		settle();
		chk("analog pin", 32'h0, {31'h0, all_in[a]});
		@(posedge clk);
		ana <= 16'h0000;
	endtask

	task automatic s_out();
		lvl <= 16'h0008;
		wr(8'h55, 32'h3);
		#1;
		chk("owned before", 32'h0, {31'h0, g2_pin_oe[5]});
		@(posedge clk);
		#1;
		chk("owned after", 32'h1, {31'h0, g2_pin_oe[5]});
		chk("drive high", 32'h1, {31'h0, g2_pin_out[5]});
		rd(8'h55, 32'h3);
		@(posedge clk);
		lvl <= 16'hFFF7;
		settle();
		chk("drive low", 32'h0, {31'h0, g2_pin_out[5]});
		@(posedge clk);
		ana <= 16'h0020;
		settle();
		chk("analog owned", 32'h0, {31'h0, g2_pin_oe[5]});
		@(posedge clk);
		ana <= 16'h0000;
		wr(8'h55, 32'h0);
		settle();
		chk("null output", 32'h0, {16'h0, g2_pin_oe});
		wr(8'h7F, 32'hF);
		settle();
		chk("group four drive", 32'h8000_8000, {g4_pin_oe, g4_pin_out});
		chk("other groups", 32'h0, {g1_pin_oe | g3_pin_oe, g1_pin_out | g3_pin_out});
	endtask

	task automatic s_lock();
		wr(8'h03, 32'h5);
		wr(8'h80, 32'h1);
		wr(8'h03, 32'hA);
		rd(8'h03, 32'h5);
		rd(8'h80, 32'h1);
		wr(8'h80, 32'h0);
		rd(8'h80, 32'h0);
		@(posedge clk);
		lock_once_opt <= 1'b1;
		wr(8'h80, 32'h1);
		wr(8'h80, 32'h0);
		wr(8'h55, 32'h7);
		rd(8'h80, 32'h3);
		rd(8'h55, 32'h0);
		do_reset();
		rd(8'h80, 32'h2);
		rd(8'hA0, 32'h0);
		@(posedge clk);
		lock_once_opt <= 1'b0;
	endtask

	initial
	begin
		#200000;
		error_cnt++;
		close_out();
	end

	initial
	begin
		do_reset();
		rd(8'h40, 32'h0);
		rd(8'h7F, 32'h0);
		chk("owned at reset", 32'h0, {16'h0, g2_pin_oe});
		s_in(8'h03, 16'h4200);
		s_in(8'h10, 16'h0000);
		s_in(8'h19, 16'h0100);
		s_in(8'h21, 16'hC400);
		s_out();
		s_lock();
		close_out();
	end
endmodule
